// File: tccs_pkg.sv
// package of timing constants and modes for the trilinear ccd clock sequencer
package tccs_pkg;
    localparam int unsigned MCLK_HZ           = 200_000_000;              // system clock rate
    localparam int unsigned PIX_FULL          = 2098;                     // pixels per line, full resolution
    localparam int unsigned PIX_SUM           = 1049;                     // pixels per line, two-pixel summing
    localparam int unsigned SHIFT_HZ          = 2_000_000;                // nominal shift clock rate
    localparam int unsigned SHIFT_DIV         = MCLK_HZ / (SHIFT_HZ * 4); // mclk cycles per quarter shift period
    localparam int unsigned XFER_NS           = 1000;                     // length of each transfer step in ns
    localparam int unsigned XFER_CYC          = (XFER_NS * (MCLK_HZ / 1_000_000) + 999) / 1000; // cycles, rounded up
    localparam int unsigned EXP_W             = 16;                       // width of the exposure delay fields
    localparam int unsigned CNT_W             = 12;                       // width of the pixel counter
    localparam logic [CNT_W-1:0] PIX_FULL_C   = CNT_W'(PIX_FULL);         // pixel count, full mode
    localparam logic [CNT_W-1:0] PIX_SUM_C    = CNT_W'(PIX_SUM);          // pixel count, summing mode
    localparam logic [1:0]       QTR_RESET    = 2'h0;                     // reset value of quarter index
    // line sequencer states
    typedef enum logic [2:0] {
        TCCS_IDLE,
        TCCS_HALT,
        TCCS_BOTH_ON,
        TCCS_INNER_OFF,
        TCCS_OUTER_OFF,
        TCCS_READ
    } tccs_state_t;
endpackage

// File: tccs_qdiv.sv
// quarter-period enable divider for the shift clocks
`timescale 1ns/1ps
module tccs_qdiv #(
    parameter int unsigned DIV = 25                 // mclk cycles per quarter period
) (
    input  wire logic mclk_i,                       // system clock
    input  wire logic reset_i,                      // synchronous reset, active high
    input  wire logic run_i,                        // divider runs while high
    output logic      tick_o                        // one-cycle pulse per quarter period
);
    logic [15:0] cnt_q;                             // cycle counter
    logic [15:0] cnt_d;                             // its next value
    logic        tick_d;                            // next tick

    // count down, pulse at wrap
    always_comb begin
        cnt_d  = cnt_q;
        tick_d = 1'b0;
        if (!run_i) begin
            cnt_d = 16'(DIV - 1);
        end else if (cnt_q == 16'h0000) begin
            cnt_d  = 16'(DIV - 1);
            tick_d = 1'b1;
        end else begin
            cnt_d = cnt_q - 16'h0001;
        end
    end

    // register the divider
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            cnt_q  <= 16'h0000;
            tick_o <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_o <= tick_d;
        end
    end
endmodule

// File: tccs_sequencer.sv
// timing generator that drives the gate clocks of a three-channel linear ccd
`timescale 1ns/1ps
// Notes on behaviour
// - overflow gate high at inner gate off, later low
// - three independent overflow gate drives
// - overflow rise placed at inner gate falling edge
// - overflow fall aligned to shift clock edge
// - summing clock half rate, 75% duty
// - full mode summing clock equals phase two
// - transfer gates at barrier during integration
// - halt with phase one high, two low
// - both on, inner off, outer off
// - resume complementary clocking after outer off
// - reset pulse before every output pixel
module tccs_sequencer
    import tccs_pkg::*;
#(
    parameter int unsigned QDIV   = tccs_pkg::SHIFT_DIV,  // mclk cycles per quarter shift period
    parameter int unsigned XCYC   = tccs_pkg::XFER_CYC    // mclk cycles per transfer step
) (
    input  wire logic                        mclk_i,               // system clock, 200 MHz
    input  wire logic                        reset_i,              // synchronous reset, active high
    input  wire logic                        enable_i,             // run line after line while high
    input  wire logic                        sum_mode_i,           // two-pixel summing when high
    input  wire logic [tccs_pkg::EXP_W-1:0]  red_exp_delay_i,      // shift periods before red overflow falls
    input  wire logic [tccs_pkg::EXP_W-1:0]  green_exp_delay_i,    // shift periods before green overflow falls
    input  wire logic [tccs_pkg::EXP_W-1:0]  blue_exp_delay_i,     // shift periods before blue overflow falls
    output logic                             phase1_o,             // phase one shift clock
    output logic                             phase2_o,             // phase two shift clock
    output logic                             summing_gate_clock_o, // last register gate clock
    output logic                             reset_clock_o,        // floating diffusion reset clock
    output logic                             inner_transfer_gate_o,// inner transfer gate, high is on
    output logic                             outer_transfer_gate_o,// outer transfer gate, high is on
    output logic                             red_overflow_gate_o,  // red overflow gate
    output logic                             green_overflow_gate_o,// green overflow gate
    output logic                             blue_overflow_gate_o, // blue overflow gate
    output logic                             line_start_o,         // pulse as readout of a line begins
    output logic                             pixel_valid_o         // pulse when a pixel sits on the outputs
);
    import tccs_pkg::*;

    tccs_state_t        state_q, state_d;          // line sequencer state
    logic [15:0]        step_q, step_d;            // transfer step timer
    logic [1:0]         qtr_q, qtr_d;              // quarter within a shift period
    logic               odd_q, odd_d;              // second pixel of a summed pair
    logic [CNT_W-1:0]   pix_q, pix_d;              // shift periods done this line
    logic [EXP_W-1:0]   per_q, per_d;              // shift periods since transfer
    logic [2:0]         ovf_q, ovf_d;              // overflow gates, r g b
    logic               p1_q, p1_d, p2_q, p2_d;    // shift phases
    logic               s2_q, s2_d, rst_q, rst_d;  // summing gate and reset clocks
    logic               tg1_q, tg1_d, tg2_q, tg2_d;// transfer gates
    logic               ls_q, ls_d, pv_q, pv_d;    // line start and pixel strobes
    logic               sum_q, sum_d;              // summing mode latched per line
    logic               tick;                      // quarter-period enable
    logic               run;                       // divider runs while reading

    assign run = (state_q == TCCS_READ);

    // quarter period enable pulses
    tccs_qdiv #(.DIV(QDIV)) u_qdiv (
        .mclk_i  (mclk_i),
        .reset_i (reset_i),
        .run_i   (run),
        .tick_o  (tick)
    );

    // overflow fall decision for one channel, only at a shift clock edge
    function automatic logic ovf_next(input logic cur, input logic [EXP_W-1:0] dly,
                                      input logic [EXP_W-1:0] per);
        ovf_next = cur && (per < dly);
    endfunction

    // line sequencer, shift and gate clocks
    always_comb begin
        state_d = state_q;
        step_d  = step_q;
        qtr_d   = qtr_q;
        odd_d   = odd_q;
        pix_d   = pix_q;
        per_d   = per_q;
        ovf_d   = ovf_q;
        p1_d    = p1_q;
        p2_d    = p2_q;
        s2_d    = s2_q;
        rst_d   = rst_q;
        tg1_d   = tg1_q;
        tg2_d   = tg2_q;
        sum_d   = sum_q;
        ls_d    = 1'b0;
        pv_d    = 1'b0;
        case (state_q)
            TCCS_IDLE: begin
                // gates at barrier, registers parked
                tg1_d = 1'b0;
                tg2_d = 1'b0;
                p1_d  = 1'b1;
                p2_d  = 1'b0;
                s2_d  = 1'b0;
                rst_d = 1'b0;
                if (enable_i) begin
                    state_d = TCCS_HALT;
                    step_d  = 16'h0000;
                end
            end
            TCCS_HALT: begin
                // clocking stopped before any transfer gate moves
                p1_d  = 1'b1;
                p2_d  = 1'b0;
                s2_d  = 1'b0;
                rst_d = 1'b0;
                if (step_q == 16'(XCYC - 1)) begin
                    state_d = TCCS_BOTH_ON;
                    step_d  = 16'h0000;
                    tg1_d   = 1'b1;
                    tg2_d   = 1'b1;
                end else begin
                    step_d = step_q + 16'h0001;
                end
            end
            TCCS_BOTH_ON: begin
                // charge moves into the inner storage region
                if (step_q == 16'(XCYC - 1)) begin
                    state_d = TCCS_INNER_OFF;
                    step_d  = 16'h0000;
                    tg1_d   = 1'b0;
                    ovf_d   = 3'h7;
                end else begin
                    step_d = step_q + 16'h0001;
                end
            end
            TCCS_INNER_OFF: begin
                // charge passes the outer gate into phase one; the exposure period count starts at readout
                if (step_q == 16'(XCYC - 1)) begin
                    state_d = TCCS_OUTER_OFF;
                    step_d  = 16'h0000;
                    tg2_d   = 1'b0;
                end else begin
                    step_d = step_q + 16'h0001;
                end
            end
            TCCS_OUTER_OFF: begin
                // settle with registers isolated, then resume readout
                if (step_q == 16'(XCYC - 1)) begin
                    state_d = TCCS_READ;
                    qtr_d   = QTR_RESET;
                    odd_d   = 1'b0;
                    pix_d   = '0;
                    per_d   = '0;
                    sum_d   = sum_mode_i;
                    ls_d    = 1'b1;
                end else begin
                    step_d = step_q + 16'h0001;
                end
            end
            TCCS_READ: begin
                if (tick) begin
                    qtr_d = qtr_q + 2'h1;
                    case (qtr_q)
                        2'h0: begin
                            // reset the floating diffusion before the next pixel
                            rst_d = ~sum_q | ~odd_q;
                        end
                        2'h1: begin
                            rst_d = 1'b0;
                            // phases swap: phase two high
                            p1_d  = 1'b0;
                            p2_d  = 1'b1;
                            s2_d  = 1'b1;
                        end
                        2'h2: begin
                            p1_d  = p1_q;
                        end
                        default: begin
                            // phases swap back, one shift period complete
                            p1_d  = 1'b1;
                            p2_d  = 1'b0;
                            // summing gate stays high across the first of a pair
                            s2_d  = sum_q & ~odd_q;
                            pv_d  = ~sum_q | odd_q;
                            odd_d = ~odd_q;
                            per_d = per_q + EXP_W'(1);
                            ovf_d = {ovf_next(ovf_q[2], red_exp_delay_i, per_d),
                                     ovf_next(ovf_q[1], green_exp_delay_i, per_d),
                                     ovf_next(ovf_q[0], blue_exp_delay_i, per_d)};
                            if (pix_q == (PIX_FULL_C - CNT_W'(1))) begin
                                // line done: next transfer only after the count
                                state_d = enable_i ? TCCS_HALT : TCCS_IDLE;
                                step_d  = 16'h0000;
                                pix_d   = '0;
                            end else begin
                                pix_d = pix_q + CNT_W'(1);
                            end
                        end
                    endcase
                end
            end
            default: begin
                state_d = TCCS_IDLE;
            end
        endcase
    end

    // register the sequencer
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            state_q <= TCCS_IDLE;
            step_q  <= 16'h0000;
            qtr_q   <= QTR_RESET;
            odd_q   <= 1'b0;
            pix_q   <= '0;
            per_q   <= '0;
            ovf_q   <= 3'h0;
            p1_q    <= 1'b1;
            p2_q    <= 1'b0;
            s2_q    <= 1'b0;
            rst_q   <= 1'b0;
            tg1_q   <= 1'b0;
            tg2_q   <= 1'b0;
            ls_q    <= 1'b0;
            pv_q    <= 1'b0;
            sum_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            step_q  <= step_d;
            qtr_q   <= qtr_d;
            odd_q   <= odd_d;
            pix_q   <= pix_d;
            per_q   <= per_d;
            ovf_q   <= ovf_d;
            p1_q    <= p1_d;
            p2_q    <= p2_d;
            s2_q    <= s2_d;
            rst_q   <= rst_d;
            tg1_q   <= tg1_d;
            tg2_q   <= tg2_d;
            ls_q    <= ls_d;
            pv_q    <= pv_d;
            sum_q   <= sum_d;
        end
    end

    // outputs straight from flops
    assign phase1_o              = p1_q;
    assign phase2_o              = p2_q;
    assign summing_gate_clock_o  = s2_q;
    assign reset_clock_o         = rst_q;
    assign inner_transfer_gate_o = tg1_q;
    assign outer_transfer_gate_o = tg2_q;
    assign red_overflow_gate_o   = ovf_q[2];
    assign green_overflow_gate_o = ovf_q[1];
    assign blue_overflow_gate_o  = ovf_q[0];
    assign line_start_o          = ls_q;
    assign pixel_valid_o         = pv_q;
endmodule

// File: tccs_monitor.sv
// port-level assertion checker for the ccd clock sequencer
`timescale 1ns/1ps
module tccs_monitor #(
    parameter int unsigned XCYC = 3         // mclk cycles per transfer step
) (
    input wire logic mclk_i,                // system clock
    input wire logic reset_i,               // synchronous reset
    input wire logic sum_mode_i,            // summing select
    input wire logic phase1_o,              // phase one
    input wire logic phase2_o,              // phase two
    input wire logic summing_gate_clock_o,  // summing gate
    input wire logic reset_clock_o,         // diffusion reset clock
    input wire logic inner_transfer_gate_o, // inner gate
    input wire logic outer_transfer_gate_o, // outer gate
    input wire logic red_overflow_gate_o,   // red overflow
    input wire logic green_overflow_gate_o, // green overflow
    input wire logic blue_overflow_gate_o,  // blue overflow
    input wire logic line_start_o,          // readout start strobe
    input wire logic pixel_valid_o          // pixel strobe
);
    logic        tg1_q, tg1_d;   // inner gate one cycle back
    logic [15:0] cnt_q, cnt_d;   // cycles since the inner gate fell, saturating
    logic        seen_q, seen_d; // a reset pulse came since the last pixel
    // next values of the helper state
    always_comb begin
        tg1_d  = inner_transfer_gate_o;
        cnt_d  = (tg1_q && !inner_transfer_gate_o) ? 16'h0001 : cnt_q + {15'h0000, ~&cnt_q};
        seen_d = pixel_valid_o ? reset_clock_o : (seen_q | reset_clock_o);
    end
    // helper registers, cleared by reset
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            tg1_q  <= 1'b0;
            cnt_q  <= 16'h0000;
            seen_q <= 1'b0;
        end else begin
            tg1_q  <= tg1_d;
            cnt_q  <= cnt_d;
            seen_q <= seen_d;
        end
    end
    default clocking dc @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    property p_halt; $rose(inner_transfer_gate_o) |-> phase1_o && !phase2_o && $stable(phase1_o); endproperty
    a_halt: assert property (p_halt) else $error("shift clocks not halted at transfer");
    property p_both_on; $rose(inner_transfer_gate_o) |-> $rose(outer_transfer_gate_o); endproperty
    a_both_on: assert property (p_both_on) else $error("gates did not open together");
    property p_outer_off; $fell(outer_transfer_gate_o) |-> cnt_q == 16'(XCYC) && !inner_transfer_gate_o; endproperty
    a_outer_off: assert property (p_outer_off) else $error("outer gate closed out of step");
    property p_ovf_high; $fell(inner_transfer_gate_o) |->
        red_overflow_gate_o && green_overflow_gate_o && blue_overflow_gate_o; endproperty
    a_ovf_high: assert property (p_ovf_high) else $error("overflow low as inner gate closed");
    property p_ovf_rise; ($rose(red_overflow_gate_o) || $rose(green_overflow_gate_o) ||
        $rose(blue_overflow_gate_o)) |-> $fell(inner_transfer_gate_o); endproperty
    a_ovf_rise: assert property (p_ovf_rise) else $error("overflow rose off the inner gate edge");
    property p_ovf_fall; ($fell(red_overflow_gate_o) || $fell(green_overflow_gate_o) ||
        $fell(blue_overflow_gate_o)) |-> $rose(phase1_o); endproperty
    a_ovf_fall: assert property (p_ovf_fall) else $error("overflow fell off a shift edge");
    property p_barrier; $changed(phase1_o) |-> !inner_transfer_gate_o && !outer_transfer_gate_o; endproperty
    a_barrier: assert property (p_barrier) else $error("shifting with a gate open");
    property p_compl; phase1_o != phase2_o; endproperty
    a_compl: assert property (p_compl) else $error("shift phases not complementary");
    property p_line_start; line_start_o |-> cnt_q == 16'(2 * XCYC); endproperty
    a_line_start: assert property (p_line_start) else $error("readout began at the wrong cycle");
    property p_full_tie; !sum_mode_i |-> summing_gate_clock_o == phase2_o; endproperty
    a_full_tie: assert property (p_full_tie) else $error("summing gate differs from phase two");
    property p_pix_reset; pixel_valid_o |-> seen_q; endproperty
    a_pix_reset: assert property (p_pix_reset) else $error("pixel without a reset pulse");
endmodule

// File: tccs_ccd_model.sv
// behavioural model of the three-channel linear ccd seen from its gate pins
`timescale 1ns/1ps
module tccs_ccd_model (
    input  wire logic        mclk_i,   // sampling clock
    input  wire logic        p1_i,     // phase one clock
    input  wire logic        sg_i,     // summing gate clock
    input  wire logic        rc_i,     // reset clock
    input  wire logic        tg1_i,    // inner transfer gate
    input  wire logic [2:0]  ovf_i,    // overflow gates, blue green red
    output logic      [15:0] pix_o,    // packets sensed in the last line
    output logic      [15:0] shf_o,    // register shifts in the last line
    output logic      [15:0] rst_o,    // diffusion resets in the last line
    output logic      [15:0] exp_o [3] // exposure cycles per channel
);
    logic        p1_q = 1'b1;       // phase one last cycle
    logic        sg_q = 1'b0;       // summing gate last cycle
    logic        rc_q = 1'b0;       // reset clock last cycle
    logic        tg_q = 1'b0;       // inner gate last cycle
    logic [15:0] pix_q = 16'h0000;  // running packet count
    logic [15:0] shf_q = 16'h0000;  // running shift count
    logic [15:0] rst_q = 16'h0000;  // running reset count
    logic [15:0] e_q [3];           // exposure accumulators
    // sample the pins and move charge on their edges
    always @(posedge mclk_i) begin
        p1_q <= p1_i;
        sg_q <= sg_i;
        rc_q <= rc_i;
        tg_q <= tg1_i;
        // the last gate dumps its summed packet as it falls
        if (sg_q && !sg_i) pix_q <= pix_q + 16'h0001;
        // each phase one rise moves all three registers one cell
        if (!p1_q && p1_i) shf_q <= shf_q + 16'h0001;
        if (!rc_q && rc_i) rst_q <= rst_q + 16'h0001;
        for (int i = 0; i < 3; i++) begin
            // charge collects only while the overflow gate is low
            e_q[i] <= ovf_i[i] ? 16'h0000 : e_q[i] + 16'h0001;
            if (tg_q && !tg1_i) exp_o[i] <= e_q[i];
        end
        // a new transfer closes the line just read out
        if (!tg_q && tg1_i) begin
            pix_o <= pix_q;
            shf_o <= shf_q;
            rst_o <= rst_q;
            pix_q <= 16'h0000;
            shf_q <= 16'h0000;
            rst_q <= 16'h0000;
        end
    end
endmodule

// File: tb.sv
// self-checking bench for the ccd clock sequencer
`timescale 1ns/1ps
module tb;
    import tccs_pkg::*;
    localparam int unsigned QD = 2;           // mclk cycles per quarter period
    localparam int unsigned XC = 3;           // mclk cycles per transfer step
    logic             mclk_i     = 1'b0;      // system clock
    logic             reset_i    = 1'b1;      // synchronous reset
    logic             enable_i   = 1'b0;      // run lines
    logic             sum_mode_i = 1'b0;      // two-pixel summing
    logic [EXP_W-1:0] red_e      = 16'h0001;  // red falls after the first period
    logic [EXP_W-1:0] grn_e      = 16'h03E8;  // green falls much later
    logic [EXP_W-1:0] blu_e      = 16'hFFFF;  // blue never falls
    logic             p1, p2, sg, rc, tg1, tg2, ls, pv; // clocks and strobes
    logic [2:0]       ovf;                    // overflow gates, blue green red
    logic [15:0]      pix, shf, rst;          // model line counts
    logic [15:0]      expo [3];               // model exposures
    int               err_total = 0;          // mismatches
    int               checks    = 0;          // comparisons
    int               pv_n      = 0;          // pixel strobes since readout began
    tccs_sequencer #(.QDIV(QD), .XCYC(XC)) dut (.mclk_i(mclk_i), .reset_i(reset_i), .enable_i(enable_i),
        .sum_mode_i(sum_mode_i), .red_exp_delay_i(red_e), .green_exp_delay_i(grn_e), .blue_exp_delay_i(blu_e),
        .phase1_o(p1), .phase2_o(p2), .summing_gate_clock_o(sg), .reset_clock_o(rc),
        .inner_transfer_gate_o(tg1), .outer_transfer_gate_o(tg2), .red_overflow_gate_o(ovf[0]),
        .green_overflow_gate_o(ovf[1]), .blue_overflow_gate_o(ovf[2]), .line_start_o(ls), .pixel_valid_o(pv));
    tccs_ccd_model u_ccd (.mclk_i(mclk_i), .p1_i(p1), .sg_i(sg), .rc_i(rc), .tg1_i(tg1), .ovf_i(ovf),
        .pix_o(pix), .shf_o(shf), .rst_o(rst), .exp_o(expo));
    // count pixel strobes, restarting at each readout start
    always @(posedge mclk_i) begin
        pv_n <= (ls === 1'b1) ? 0 : pv_n + ((pv === 1'b1) ? 1 : 0);
    end
    // free-running clock
    initial begin
        forever #2.5 mclk_i = ~mclk_i;
    end
    // compare one value and count it
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask
    // one clock, then let that edge settle
    task automatic step();
        @(posedge mclk_i);
        #1;
    endtask
    // bounded wait for the inner gate to reach a level
    task automatic wait_tg(input logic lvl);
        int n;
        n = 0;
        step();
        while (tg1 !== lvl && n < 20000) begin
            step();
            n++;
        end
        if (n >= 20000) cmp(16'h0000, 16'h0001, "inner gate stuck");
    endtask
    // print the counts and the verdict, then stop
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // outputs right after reset: clocks halted, gates shut
    task automatic t_reset();
        cmp({15'h0000, p1}, 16'h0001, "phase one after reset");
        cmp({6'h00, p2, sg, rc, tg1, tg2, ovf, ls, pv}, 16'h0000, "outputs after reset");
        $display("test reset done");
    endtask
    // one full-resolution line with three different exposures
    task automatic t_full();
        enable_i = 1'b1;
        wait_tg(1'b1);
        wait_tg(1'b0);
        wait_tg(1'b1);
        sum_mode_i = 1'b1;
        step();
        cmp(pix, 16'(PIX_FULL_C), "full line packets");
        cmp(shf, 16'(PIX_FULL_C), "full line shifts");
        cmp(rst, 16'(PIX_FULL_C), "full line resets");
        cmp(16'(pv_n), 16'(PIX_FULL_C), "full line pixel strobes");
        wait_tg(1'b0);
        step();
        cmp(expo[2], 16'h0000, "blue held in the drain");
        cmp(expo[0] - expo[1], 16'((grn_e - red_e) * 4 * QD), "red minus green exposure");
        $display("test full done");
    endtask
    // one summed line, then enable drops
    task automatic t_sum();
        wait_tg(1'b1);
        enable_i = 1'b0;
        step();
        cmp(pix, 16'(PIX_SUM_C), "summed line packets");
        cmp(rst, 16'(PIX_SUM_C), "summed line resets");
        cmp(16'(pv_n), 16'(PIX_SUM_C), "summed line pixel strobes");
        cmp(shf, 16'(PIX_FULL_C), "summed line shifts");
        $display("test sum done");
    endtask
    // last line runs out and no new transfer starts
    task automatic t_stop();
        int   rises;
        logic last;
        rises = 0;
        last = tg1;
        repeat (20000) begin
            step();
            if (tg1 === 1'b1 && last !== 1'b1) rises++;
            last = tg1;
        end
        cmp(16'(rises), 16'h0000, "transfer after enable dropped");
        cmp({14'h0000, p1, p2}, 16'h0002, "idle shift clocks");
        $display("test stop done");
    endtask
    // main sequence
    initial begin
        repeat (2) @(posedge mclk_i);
        #1;
        reset_i = 1'b0;
        t_reset();
        t_full();
        t_sum();
        t_stop();
        end_sim();
    end
    // watchdog against a hang
    initial begin
        #(70000 * 5);
        err_total++;
        end_sim();
    end
endmodule
bind tccs_sequencer tccs_monitor #(.XCYC(XCYC)) u_mon (.mclk_i(mclk_i), .reset_i(reset_i),
    .sum_mode_i(sum_mode_i), .phase1_o(phase1_o), .phase2_o(phase2_o),
    .summing_gate_clock_o(summing_gate_clock_o), .reset_clock_o(reset_clock_o),
    .inner_transfer_gate_o(inner_transfer_gate_o), .outer_transfer_gate_o(outer_transfer_gate_o),
    .red_overflow_gate_o(red_overflow_gate_o), .green_overflow_gate_o(green_overflow_gate_o),
    .blue_overflow_gate_o(blue_overflow_gate_o), .line_start_o(line_start_o), .pixel_valid_o(pixel_valid_o));
